/* File: pkg/ssa_pkg.sv */
package ssa_pkg;
    // Component numbering and table shape
    localparam int NCOMP = 10;
    localparam int OFF_W = 16;
    localparam int ADDR_W = 32;
    localparam logic [3:0] COMP_FP = 4'h0;
    localparam logic [3:0] COMP_VEC = 4'h1;
    localparam logic [3:0] COMP_EXT_MIN = 4'h2;
    localparam logic [3:0] COMP_HDR = 4'hF;
    // Extended components the block knows: 2, 5, 6, 7, 9
    localparam logic [9:0] EXT_SUPPORTED = 10'h2E4;
    localparam int COMPACT_BIT = 63;

    // Area layout
    localparam logic [15:0] LEG_OFF = 16'h0000;
    localparam logic [15:0] LEG_USED_END = 16'h01A0;
    localparam logic [15:0] LEG_RSVD_END = 16'h01D0;
    localparam logic [15:0] HDR_OFF = 16'h0200;
    localparam logic [15:0] HDR_SIZE = 16'h0040;
    localparam logic [15:0] HDR_RSVD_OFF = 16'h0010;
    localparam logic [15:0] HDR_PRESENT_OFF = 16'h0000;
    localparam logic [15:0] HDR_COMPACT_OFF = 16'h0008;
    localparam logic [15:0] EXT_OFF = 16'h0240;
    localparam logic [15:0] AREA_ALIGN = 16'h0040;
    localparam logic [5:0] BASE_ALIGN_MASK = 6'h3F;

    // Legacy split pieces, component-relative byte ranges
    localparam logic [15:0] FP_A_LEN = 16'h0018;
    localparam logic [15:0] FP_B_OFF = 16'h0020;
    localparam logic [15:0] FP_B_LEN = 16'h0080;
    localparam logic [15:0] VEC_A_OFF = 16'h0018;
    localparam logic [15:0] VEC_A_LEN = 16'h0008;
    localparam logic [15:0] VEC_B_OFF = 16'h00A0;
    localparam logic [15:0] VEC_B_LEN = 16'h0100;

    // Named legacy fields
    localparam logic [15:0] FP_CTRL_OFF = 16'h0000;
    localparam logic [15:0] FP_STAT_OFF = 16'h0002;
    localparam logic [15:0] FP_OPC_OFF = 16'h0006;
    localparam logic [15:0] VCS_OFF = 16'h0018;
    localparam logic [15:0] SLOT_SIZE = 16'h0010;
    localparam logic [15:0] ST_BASE = 16'h0020;
    localparam logic [15:0] VR_BASE = 16'h00A0;
    localparam logic [3:0] ST_COUNT = 4'h8;

    // Register indices
    localparam logic [3:0] REG_BASE = 4'h0;
    localparam logic [3:0] REG_XCOMP_LO = 4'h1;
    localparam logic [3:0] REG_XCOMP_HI = 4'h2;
    localparam logic [3:0] REG_PRES_LO = 4'h3;
    localparam logic [3:0] REG_PRES_HI = 4'h4;
    localparam logic [3:0] REG_UMASK = 4'h5;
    localparam logic [3:0] REG_SMASK = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;
    localparam logic [3:0] REG_EXT_END = 4'h8;

    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    localparam logic [31:0] UMASK_RST = 32'h00000001;

    // Request field selector
    typedef enum logic [2:0] {
        FLD_RAW = 3'b000,
        FLD_CTRL = 3'b001,
        FLD_STAT = 3'b010,
        FLD_OPC = 3'b011,
        FLD_VCS = 3'b100,
        FLD_STREG = 3'b101,
        FLD_VREG = 3'b110
    } ssa_field_t;

    // Round up to the next 64-byte boundary
    function automatic logic [15:0] ssa_ceil64(input logic [15:0] v);
        return (v + (AREA_ALIGN - 16'h0001)) & ~(AREA_ALIGN - 16'h0001);
    endfunction
endpackage

/* File: rtl/ssa_compact_calc.sv */
`timescale 1ns/10ps
module ssa_compact_calc #(
    parameter int NCOMP = ssa_pkg::NCOMP
) (
    input wire logic compact_i, // Compacted layout chosen
    input wire logic [NCOMP-1:0] keep_i, // Components given space
    input wire logic [NCOMP*16-1:0] size_i, // Enumerated sizes
    input wire logic [NCOMP*16-1:0] std_off_i, // Enumerated fixed offsets
    input wire logic [NCOMP-1:0] align_i, // Enumerated 64-byte align flags
    output logic [NCOMP*16-1:0] loc_o, // Offset of each component
    output logic [15:0] end_o // First byte past the area
);
    // Walk components upward; compacted packs them, standard uses fixed slots
    always_comb begin
        logic [15:0] run;
        logic [15:0] here;
        logic [15:0] top;
        run = ssa_pkg::EXT_OFF;
        here = ssa_pkg::EXT_OFF;
        top = ssa_pkg::EXT_OFF;
        loc_o = '0;
        for (int i = 2; i < NCOMP; i++) begin
            if (compact_i) begin
                here = align_i[i] ? ssa_pkg::ssa_ceil64(run) : run;
                if (keep_i[i]) begin
                    loc_o[i*16 +: 16] = here;
                    run = here + size_i[i*16 +: 16];
                    top = run;
                end
            end else begin
                loc_o[i*16 +: 16] = std_off_i[i*16 +: 16];
                here = std_off_i[i*16 +: 16] + size_i[i*16 +: 16];
                if (keep_i[i] && here > top) begin
                    top = here;
                end
            end
        end
        end_o = top;
    end
endmodule // ssa_compact_calc

/* File: rtl/ssa_layout.sv */
// Contract
// - Legacy region is the first 512 bytes from the base.
// - Header is 64 bytes starting 512 bytes above the base.
// - Extended region starts at 576 and holds components 2 and up.
// - Extended size follows implemented components and both enable masks; compacted layout sizes by the compaction bitmap instead.
// - Floating-point stack uses legacy bytes 23:0 and 159:32.
// - Vector component uses legacy bytes 31:24 and 415:160.
// - Legacy bytes 511:416 never touched; 463:416 reserved.
// - Header bytes 7:0 are the present-components bitmap.
// - Header bytes 15:8 are the compaction bitmap; bit 63 picks layout.
// - Restore uses compacted form when bit 63 set, else standard.
// - Header bytes 63:16 are reserved.
// - Extended components known: 2, 5 to 7, and 9.
// - Standard layout always; compacted only with compaction support.
// - Standard layout places components at enumerated offset and size.
// - Compacted layout gives no space to components with clear bit.
// - First present compacted component sits at offset 576.
// - Unaligned compacted component follows previous offset plus size.
// - Aligned compacted component rounds previous end up to 64 bytes.
// - Control word bytes 1:0, status bytes 3:2, last opcode 7:6.
// - Vector control and status word sits at legacy bytes 27:24.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module ssa_layout #(
    parameter int NCOMP = ssa_pkg::NCOMP,
    parameter bit COMPACT_EN = 1'b1
) (
    input wire logic clock_i, // Core clock, 20 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic [3:0] reg_addr_i, // Register index
    input wire logic [31:0] reg_wdata_i, // Register write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
    input wire logic [NCOMP*16-1:0] ext_size_i, // Enumerated component sizes
    input wire logic [NCOMP*16-1:0] ext_std_off_i, // Enumerated standard offsets
    input wire logic [NCOMP-1:0] ext_align_i, // Enumerated align flags
    input wire logic req_valid_i, // Sequencer address request
    input wire logic [3:0] req_comp_i, // Component, or header code
    input wire logic [2:0] req_field_i, // Named field selector
    input wire logic [3:0] req_index_i, // Register slot number
    input wire logic [15:0] req_byte_i, // Byte within component or slot
    input wire logic req_restore_i, // Request belongs to a restore
    output logic [31:0] addr_o, // Memory byte address
    output logic [15:0] offset_o, // Offset from the base
    output logic [15:0] comp_size_o, // Size of addressed component
    output logic addr_valid_o, // Answer strobe
    output logic addr_err_o, // Byte is outside any usable place, base not 64-byte aligned, or bit 63 set without compaction support
    output logic comp_present_o, // Present bit of addressed component
    output logic restore_compact_o // Restore uses compacted form
);
    // Register images
    logic [31:0] base_r;
    logic [63:0] xcomp_r;
    logic [63:0] present_r;
    logic [31:0] umask_r;
    logic [31:0] smask_r;

    // Read path and layout flags
    logic [31:0] rdata_nxt;
    logic base_bad;
    logic compact_fmt;
    logic fmt_err;

    // Extended layout and next answer
    logic [NCOMP-1:0] enabled;
    logic [NCOMP-1:0] keep;
    logic [NCOMP*16-1:0] loc;
    logic [15:0] area_end;
    logic [15:0] off_nxt;
    logic [15:0] size_nxt;
    logic err_nxt;
    logic pres_nxt;
    // Sixteen vector slots, so the count needs a fifth bit
    localparam logic [4:0] VR_SLOTS = 5'h10;

    // Legacy pieces: a component-relative byte lands in one of two windows
    function automatic logic [16:0] split_map(input logic [15:0] b, input logic [15:0] a_off,
                                              input logic [15:0] a_len, input logic [15:0] b_off,
                                              input logic [15:0] b_len);
        if (b < a_len) begin
            return {1'b0, a_off + b};
        end else if (b < a_len + b_len) begin
            return {1'b0, b_off + (b - a_len)};
        end
        return {1'b1, 16'h0000};
    endfunction

    // Fixed 16-byte register slot
    function automatic logic [16:0] slot_map(input logic [15:0] slot_base, input logic [3:0] idx,
                                             input logic [4:0] count, input logic [15:0] b);
        logic [15:0] slot_off;
        slot_off = slot_base + ssa_pkg::SLOT_SIZE * {12'h000, idx};
        if ({1'b0, idx} >= count || b >= ssa_pkg::SLOT_SIZE) begin
            return {1'b1, 16'h0000};
        end
        return {1'b0, slot_off + b};
    endfunction

    // Layout choice and misuse flags
    assign compact_fmt = xcomp_r[ssa_pkg::COMPACT_BIT] & COMPACT_EN;
    assign fmt_err = xcomp_r[ssa_pkg::COMPACT_BIT] & ~COMPACT_EN;
    assign base_bad = |(base_r[5:0] & ssa_pkg::BASE_ALIGN_MASK);
    assign enabled = (umask_r[NCOMP-1:0] | smask_r[NCOMP-1:0]) & ssa_pkg::EXT_SUPPORTED;
    assign keep = compact_fmt ? (xcomp_r[NCOMP-1:0] & ssa_pkg::EXT_SUPPORTED) : enabled;

    // Extended offsets for both layouts
    ssa_compact_calc #(
        .NCOMP(NCOMP)
    ) u_calc (
        .compact_i(compact_fmt),
        .keep_i(keep),
        .size_i(ext_size_i),
        .std_off_i(ext_std_off_i),
        .align_i(ext_align_i),
        .loc_o(loc),
        .end_o(area_end)
    );

    // Offset of the requested byte, pure function of request and tables
    always_comb begin
        logic [16:0] m;
        int c;
        c = int'(req_comp_i);
        m = {1'b1, 16'h0000};
        size_nxt = 16'h0000;
        pres_nxt = 1'b0;
        case (req_field_i)
            ssa_pkg::FLD_CTRL: m = {1'b0, ssa_pkg::FP_CTRL_OFF};
            ssa_pkg::FLD_STAT: m = {1'b0, ssa_pkg::FP_STAT_OFF};
            ssa_pkg::FLD_OPC: m = {1'b0, ssa_pkg::FP_OPC_OFF};
            ssa_pkg::FLD_VCS: m = {1'b0, ssa_pkg::VCS_OFF};
            ssa_pkg::FLD_STREG: m = slot_map(ssa_pkg::ST_BASE, req_index_i, {1'b0, ssa_pkg::ST_COUNT},
                                             req_byte_i);
            ssa_pkg::FLD_VREG: m = slot_map(ssa_pkg::VR_BASE, req_index_i, VR_SLOTS, req_byte_i);
            ssa_pkg::FLD_RAW: begin
                if (req_comp_i == ssa_pkg::COMP_FP) begin
                    m = split_map(req_byte_i, ssa_pkg::LEG_OFF, ssa_pkg::FP_A_LEN,
                                  ssa_pkg::FP_B_OFF, ssa_pkg::FP_B_LEN);
                    size_nxt = ssa_pkg::FP_A_LEN + ssa_pkg::FP_B_LEN;
                end else if (req_comp_i == ssa_pkg::COMP_VEC) begin
                    m = split_map(req_byte_i, ssa_pkg::VEC_A_OFF, ssa_pkg::VEC_A_LEN,
                                  ssa_pkg::VEC_B_OFF, ssa_pkg::VEC_B_LEN);
                    size_nxt = ssa_pkg::VEC_A_LEN + ssa_pkg::VEC_B_LEN;
                end else if (req_comp_i == ssa_pkg::COMP_HDR) begin
                    // Bitmaps at bytes 15:0, reserved tail refused
                    m = {req_byte_i >= ssa_pkg::HDR_RSVD_OFF, ssa_pkg::HDR_OFF + req_byte_i};
                    size_nxt = ssa_pkg::HDR_SIZE;
                end else if (c < NCOMP) begin
                    size_nxt = ext_size_i[c*16 +: 16];
                    m = {~keep[c] | (req_byte_i >= size_nxt), loc[c*16 +: 16] + req_byte_i};
                end
            end
            default: m = {1'b1, 16'h0000};
        endcase
        if (req_comp_i != ssa_pkg::COMP_HDR && c < NCOMP) begin
            pres_nxt = present_r[c];
        end else if (req_comp_i == ssa_pkg::COMP_HDR) begin
            pres_nxt = 1'b1;
        end
        // Legacy never reaches past its used part
        if (m[15:0] >= ssa_pkg::LEG_USED_END && m[15:0] < ssa_pkg::HDR_OFF) begin
            m[16] = 1'b1;
        end
        off_nxt = m[15:0];
        err_nxt = m[16] | base_bad | fmt_err;
    end

    // Base address register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            base_r <= ssa_pkg::RST_ZERO;
        end else if (reg_wr_i && reg_addr_i == ssa_pkg::REG_BASE) begin
            base_r <= reg_wdata_i;
        end
    end

    // Header bitmap images, loaded by the sequencer through the register port
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            xcomp_r <= {ssa_pkg::RST_ZERO, ssa_pkg::RST_ZERO};
            present_r <= {ssa_pkg::RST_ZERO, ssa_pkg::RST_ZERO};
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ssa_pkg::REG_XCOMP_LO: xcomp_r[31:0] <= reg_wdata_i;
                ssa_pkg::REG_XCOMP_HI: xcomp_r[63:32] <= reg_wdata_i;
                ssa_pkg::REG_PRES_LO: present_r[31:0] <= reg_wdata_i;
                ssa_pkg::REG_PRES_HI: present_r[63:32] <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // Enable masks; component 0 can never be switched off
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            umask_r <= ssa_pkg::UMASK_RST;
            smask_r <= ssa_pkg::RST_ZERO;
        end else if (reg_wr_i && reg_addr_i == ssa_pkg::REG_UMASK) begin
            umask_r <= reg_wdata_i | ssa_pkg::UMASK_RST;
        end else if (reg_wr_i && reg_addr_i == ssa_pkg::REG_SMASK) begin
            smask_r <= reg_wdata_i;
        end
    end

    // Read mux; unmapped indices read zero
    always_comb begin
        case (reg_addr_i)
            ssa_pkg::REG_BASE: rdata_nxt = base_r;
            ssa_pkg::REG_XCOMP_LO: rdata_nxt = xcomp_r[31:0];
            ssa_pkg::REG_XCOMP_HI: rdata_nxt = xcomp_r[63:32];
            ssa_pkg::REG_PRES_LO: rdata_nxt = present_r[31:0];
            ssa_pkg::REG_PRES_HI: rdata_nxt = present_r[63:32];
            ssa_pkg::REG_UMASK: rdata_nxt = umask_r;
            ssa_pkg::REG_SMASK: rdata_nxt = smask_r;
            ssa_pkg::REG_STATUS: rdata_nxt = {29'h00000000, fmt_err, base_bad, compact_fmt};
            ssa_pkg::REG_EXT_END: rdata_nxt = {16'h0000, area_end};
            default: rdata_nxt = ssa_pkg::RST_ZERO;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            reg_rdata_o <= ssa_pkg::RST_ZERO;
        end else begin
            reg_rdata_o <= reg_rd_i ? rdata_nxt : ssa_pkg::RST_ZERO;
        end
    end

    // Answer strobe, one cycle per request
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            addr_valid_o <= 1'b0;
        end else begin
            addr_valid_o <= req_valid_i;
        end
    end

    // Answer data held until the next request
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            addr_o <= ssa_pkg::RST_ZERO;
            offset_o <= 16'h0000;
            comp_size_o <= 16'h0000;
            addr_err_o <= 1'b0;
            comp_present_o <= 1'b0;
            restore_compact_o <= 1'b0;
        end else if (req_valid_i) begin
            addr_o <= base_r + {16'h0000, off_nxt};
            offset_o <= off_nxt;
            comp_size_o <= size_nxt;
            addr_err_o <= err_nxt;
            comp_present_o <= pres_nxt;
            restore_compact_o <= req_restore_i & compact_fmt;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    sequence raw_req_s(logic [3:0] comp);
        req_valid_i && req_field_i == ssa_pkg::FLD_RAW && req_comp_i == comp && !base_bad && !fmt_err;
    endsequence

    sequence good_answer_s;
        addr_valid_o && !addr_err_o;
    endsequence

    // Each answer is judged one edge after its request
    leg_bound_a: assert property (good_answer_s and (offset_o < ssa_pkg::HDR_OFF)
            |-> offset_o < ssa_pkg::LEG_USED_END)
        else $error("legacy answer beyond used bytes");

    fp_split_a: assert property (raw_req_s(ssa_pkg::COMP_FP) ##0 (req_byte_i < ssa_pkg::FP_A_LEN)
            |=> good_answer_s ##0 offset_o == $past(req_byte_i))
        else $error("stack low bytes misplaced");

    vec_split_a: assert property (raw_req_s(ssa_pkg::COMP_VEC) ##0 (req_byte_i < ssa_pkg::VEC_A_LEN)
            |=> good_answer_s ##0 offset_o == ssa_pkg::VEC_A_OFF + $past(req_byte_i))
        else $error("vector low bytes misplaced");

    ctrl_words_a: assert property (req_valid_i && req_field_i inside {ssa_pkg::FLD_CTRL, ssa_pkg::FLD_STAT}
            |=> offset_o == (($past(req_field_i) == ssa_pkg::FLD_CTRL) ? ssa_pkg::FP_CTRL_OFF
                                                                       : ssa_pkg::FP_STAT_OFF))
        else $error("control or status word misplaced");

    vcs_place_a: assert property (req_valid_i && req_field_i == ssa_pkg::FLD_VCS
            |=> offset_o == ssa_pkg::VCS_OFF)
        else $error("vector control word misplaced");

    st_slot_a: assert property (req_valid_i && req_field_i == ssa_pkg::FLD_STREG && !base_bad && !fmt_err
            && req_index_i < ssa_pkg::ST_COUNT && req_byte_i < ssa_pkg::SLOT_SIZE
            |=> good_answer_s ##0 offset_o == ssa_pkg::ST_BASE
                + ssa_pkg::SLOT_SIZE * {12'h000, $past(req_index_i)} + $past(req_byte_i))
        else $error("stack slot misplaced");

    hdr_place_a: assert property (raw_req_s(ssa_pkg::COMP_HDR) ##0 (req_byte_i < ssa_pkg::HDR_RSVD_OFF)
            |=> good_answer_s ##0 offset_o == ssa_pkg::HDR_OFF + $past(req_byte_i))
        else $error("header byte misplaced");

    hdr_rsvd_a: assert property (req_valid_i && req_field_i == ssa_pkg::FLD_RAW && req_comp_i == ssa_pkg::COMP_HDR
            && req_byte_i >= ssa_pkg::HDR_RSVD_OFF |=> addr_valid_o && addr_err_o)
        else $error("reserved header byte accepted");

    first_ext_a: assert property (raw_req_s(ssa_pkg::COMP_EXT_MIN) ##0 (compact_fmt && xcomp_r[2]
            && req_byte_i == 16'h0000) |=> offset_o == ssa_pkg::EXT_OFF)
        else $error("first compacted component not at extended start");

    absent_cmp_a: assert property (req_valid_i && req_field_i == ssa_pkg::FLD_RAW && compact_fmt
            && req_comp_i >= ssa_pkg::COMP_EXT_MIN && req_comp_i < 4'(NCOMP) && !xcomp_r[req_comp_i]
            |=> addr_err_o)
        else $error("absent compacted component given space");

    ext_floor_a: assert property (req_valid_i && req_field_i == ssa_pkg::FLD_RAW
            && req_comp_i >= ssa_pkg::COMP_EXT_MIN && req_comp_i != ssa_pkg::COMP_HDR
            |=> addr_err_o || offset_o >= ssa_pkg::EXT_OFF)
        else $error("extended component below extended start");

    restore_form_a: assert property (req_valid_i && req_restore_i
            |=> restore_compact_o == $past(xcomp_r[ssa_pkg::COMPACT_BIT] & COMPACT_EN))
        else $error("restore form disagrees with bit 63");

    base_addr_a: assert property (req_valid_i
            |=> addr_o == $past(base_r) + {16'h0000, offset_o})
        else $error("address not base plus offset");

    vr_slot_a: assert property (req_valid_i && req_field_i == ssa_pkg::FLD_VREG && !base_bad && !fmt_err
            && req_byte_i < ssa_pkg::SLOT_SIZE |=> good_answer_s ##0 offset_o == ssa_pkg::VR_BASE
                + ssa_pkg::SLOT_SIZE * {12'h000, $past(req_index_i)} + $past(req_byte_i))
        else $error("vector slot misplaced");

    pres_bit_a: assert property (req_valid_i && req_field_i == ssa_pkg::FLD_RAW && req_comp_i < 4'(NCOMP)
            |=> comp_present_o == $past(present_r[req_comp_i]))
        else $error("present bit not reported");

    valid_pulse_a: assert property (addr_valid_o == $past(req_valid_i))
        else $error("answer strobe out of step");
endmodule // ssa_layout

/* File: verif/ssa_mem_model.sv */
`timescale 1ns/10ps
module ssa_mem_model (
    input wire logic clock_i, // Core clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic valid_i, // Address strobe from the block
    input wire logic err_i, // Address refused by the block
    input wire logic [15:0] offset_i, // Offset into the save area
    output logic hit_unused_o // Unused legacy bytes were touched
);
    // Sticky flag, so a single stray access is never lost between checks
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            hit_unused_o <= 1'b0;
        end else if (valid_i && !err_i && offset_i >= 16'h01A0 && offset_i < 16'h0200) begin
            hit_unused_o <= 1'b1;
        end
    end
endmodule // ssa_mem_model

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    localparam logic [15:0] SZ [10] = '{16'h00A0, 16'h0100, 16'h0104, 16'h0000, 16'h0000, 16'h0040,
                                        16'h01F8, 16'h0400, 16'h0000, 16'h0008};
    localparam logic [15:0] OF [10] = '{16'h0000, 16'h0000, 16'h0240, 16'h0000, 16'h0000, 16'h0380,
                                        16'h03C0, 16'h05C0, 16'h0000, 16'h09C0};
    localparam logic [9:0] AL = 10'h220;
    logic clock_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, req_valid_i = 1'b0, req_restore_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0, req_comp_i = 4'h0, req_index_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h00000000, reg_rdata_o, addr_o, base, d;
    logic [2:0] req_field_i = 3'h0;
    logic [15:0] req_byte_i = 16'h0000, offset_o, comp_size_o;
    logic [159:0] sizes, offs;
    logic addr_valid_o, addr_err_o, comp_present_o, restore_compact_o, hit_unused;
    int err_count = 0, checked = 0, cycles = 0;
    logic [3:0] i;
    logic [15:0] b;
    int ext_c [5] = '{2, 5, 6, 7, 9};
    for (genvar g = 0; g < 10; g++) begin : g_tab
        assign sizes[g*16+:16] = SZ[g];
        assign offs[g*16+:16] = OF[g];
    end
    ssa_layout dut_u (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ext_size_i(sizes),
        .ext_std_off_i(offs), .ext_align_i(AL), .req_valid_i(req_valid_i), .req_comp_i(req_comp_i),
        .req_field_i(req_field_i), .req_index_i(req_index_i), .req_byte_i(req_byte_i),
        .req_restore_i(req_restore_i), .addr_o(addr_o), .offset_o(offset_o), .comp_size_o(comp_size_o),
        .addr_valid_o(addr_valid_o), .addr_err_o(addr_err_o), .comp_present_o(comp_present_o),
        .restore_compact_o(restore_compact_o));
    ssa_mem_model mem_u (.clock_i(clock_i), .rst_i(rst_i), .valid_i(addr_valid_o), .err_i(addr_err_o),
        .offset_i(offset_o), .hit_unused_o(hit_unused));
    // Free-running core clock, 50 ns period
    initial begin
        forever #25 clock_i = ~clock_i;
    end
    // Expected packed offset, own walk
    function automatic logic [15:0] cloc(input int c, input logic [9:0] keep);
        logic [15:0] loc;
        int p;
        loc = 16'h0240;
        p = -1;
        for (int j = 2; j <= c; j++) begin
            if (keep[j]) begin
                if (p >= 0) loc = AL[j] ? ((loc + SZ[p] + 16'h003F) & 16'hFFC0) : (loc + SZ[p]);
                p = j;
            end
        end
        return loc;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    // One request; answer is looked at in the single cycle it stands
    task automatic req(input logic [3:0] c, input logic [2:0] f, input logic [3:0] x, input logic [15:0] y,
                       input logic rs, input logic [15:0] eo, input logic ee);
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        req_comp_i <= c;
        req_field_i <= f;
        req_index_i <= x;
        req_byte_i <= y;
        req_restore_i <= rs;
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        #1 check("valid", {31'h0, addr_valid_o}, 32'h1);
        check("error", {31'h0, addr_err_o}, {31'h0, ee});
        if (!ee) begin
            check("offset", {16'h0, offset_o}, {16'h0, eo});
            check("address", addr_o, base + {16'h0, eo});
        end
    endtask
    task automatic summarize();
        $display("Checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, far above the run length
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        void'($urandom(26));
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(ssa_pkg::REG_UMASK, d);
        check("user mask", d, ssa_pkg::UMASK_RST);
        rd(ssa_pkg::REG_SMASK, d);
        check("supervisor mask", d, ssa_pkg::RST_ZERO);
        rd(4'h9, d);
        check("unmapped", d, 32'h00000000);
        base = $urandom & 32'hFFFFFFC0;
        wr(ssa_pkg::REG_BASE, base);
        req(ssa_pkg::COMP_FP, 3'h0, 4'h0, 16'h0000, 1'b0, 16'h0000, 1'b0);
        req(ssa_pkg::COMP_FP, 3'h0, 4'h0, 16'h0018, 1'b0, 16'h0020, 1'b0);
        req(ssa_pkg::COMP_FP, 3'h0, 4'h0, 16'h0097, 1'b0, 16'h009F, 1'b0);
        req(ssa_pkg::COMP_VEC, 3'h0, 4'h0, 16'h0000, 1'b0, 16'h0018, 1'b0);
        req(ssa_pkg::COMP_VEC, 3'h0, 4'h0, 16'h0008, 1'b0, 16'h00A0, 1'b0);
        req(ssa_pkg::COMP_VEC, 3'h0, 4'h0, 16'h0107, 1'b0, 16'h019F, 1'b0);
        req(ssa_pkg::COMP_VEC, 3'h0, 4'h0, 16'h0108, 1'b0, 16'h0000, 1'b1);
        req(4'h0, 3'h1, 4'h0, 16'h0000, 1'b0, 16'h0000, 1'b0);
        req(4'h0, 3'h2, 4'h0, 16'h0000, 1'b0, 16'h0002, 1'b0);
        req(4'h0, 3'h3, 4'h0, 16'h0000, 1'b0, 16'h0006, 1'b0);
        req(4'h0, 3'h4, 4'h0, 16'h0000, 1'b0, 16'h0018, 1'b0);
        repeat (16) begin
            i = 4'($urandom_range(7));
            b = 16'($urandom_range(15));
            req(4'h0, 3'h5, i, b, 1'b0, 16'h0020 + {8'h00, i, 4'h0} + b, 1'b0);
            i = 4'($urandom_range(15));
            req(4'h0, 3'h6, i, b, 1'b0, 16'h00A0 + {8'h00, i, 4'h0} + b, 1'b0);
        end
        req(ssa_pkg::COMP_HDR, 3'h0, 4'h0, 16'h0000, 1'b0, 16'h0200, 1'b0);
        req(ssa_pkg::COMP_HDR, 3'h0, 4'h0, 16'h0008, 1'b0, 16'h0208, 1'b0);
        req(ssa_pkg::COMP_HDR, 3'h0, 4'h0, 16'h0010, 1'b0, 16'h0000, 1'b1);
        d = $urandom;
        wr(ssa_pkg::REG_PRES_LO, d);
        wr(ssa_pkg::REG_UMASK, 32'h00000024);
        wr(ssa_pkg::REG_SMASK, 32'h000002C0);
        foreach (ext_c[k]) begin
            req(ext_c[k][3:0], 3'h0, 4'h0, 16'h0000, 1'b1, OF[ext_c[k]], 1'b0);
            check("size", {16'h0, comp_size_o}, {16'h0, SZ[ext_c[k]]});
            check("present", {31'h0, comp_present_o}, {31'h0, d[ext_c[k]]});
        end
        check("standard restore", {31'h0, restore_compact_o}, 32'h0);
        rd(ssa_pkg::REG_EXT_END, d);
        check("standard end", d, {16'h0, OF[9] + SZ[9]});
        req(4'h3, 3'h0, 4'h0, 16'h0000, 1'b0, 16'h0000, 1'b1);
        req(4'h2, 3'h0, 4'h0, SZ[2], 1'b0, 16'h0000, 1'b1);
        wr(ssa_pkg::REG_XCOMP_LO, 32'h00000264);
        wr(ssa_pkg::REG_XCOMP_HI, 32'h80000000);
        rd(ssa_pkg::REG_STATUS, d);
        check("compacted flag", {31'h0, d[0]}, 32'h1);
        foreach (ext_c[k]) req(ext_c[k][3:0], 3'h0, 4'h0, 16'h0000, 1'b1, cloc(ext_c[k], 10'h264),
                               ext_c[k] == 7);
        check("compact restore", {31'h0, restore_compact_o}, 32'h1);
        rd(ssa_pkg::REG_EXT_END, d);
        check("compact end", d, {16'h0, cloc(9, 10'h264) + SZ[9]});
        base = base | 32'h00000004;
        wr(ssa_pkg::REG_BASE, base);
        req(ssa_pkg::COMP_FP, 3'h0, 4'h0, 16'h0000, 1'b0, 16'h0000, 1'b1);
        check("unused legacy", {31'h0, hit_unused}, 32'h0);
        summarize();
    end
endmodule // tb_top
